// ---- mce_alu.sv ----
`timescale 1ns/100ps
`default_nettype none
module mce_alu
(
	// Operation
	input  wire mce_pkg::mce_op_e op,
	input  wire logic [7:0]       accIn,
	input  wire logic [7:0]       fileIn,
	input  wire logic [7:0]       lit,
	input  wire logic [2:0]       bitSel,
	// Result
	output logic [7:0]            result,
	output logic                  carry,
	output logic                  halfCarry,
	output logic                  zero
);
	import mce_pkg::*;

	logic [8:0] sum9;
	logic [4:0] sum5;

	assign sum9 = {1'b0, accIn} + {1'b0, fileIn};
	assign sum5 = {1'b0, accIn[3:0]} + {1'b0, fileIn[3:0]};

	always_comb
	begin
		result = fileIn;
		unique case (op)
			OP_ADD_REGISTER_INSTR: result = sum9[7:0];
			OP_AND_REGISTER_INSTR: result = accIn & fileIn;
			OP_AND_LITERAL_INSTR: result = accIn & lit;
			OP_BCF:   result = fileIn & ~(8'h01 << bitSel);
			OP_BSF:   result = fileIn | (8'h01 << bitSel);
			default:  result = fileIn;
		endcase
	end

	// Carry out of bit 7, half-byte overflow out of bit 3
	assign carry     = sum9[8];
	assign halfCarry = sum5[4];
	assign zero      = (result == 8'h00);
endmodule // mce_alu
`default_nettype wire

// ---- mce_exec.sv ----
// Summary of operation
// - PC writes by instructions except branch clear bit nine
// - Port read-modify-write uses actual pin levels
// - Direction load f=6 copies accumulator, one=high-Z
// - Flagged write to timer clears assigned prescaler
// - Add register: sum, updates C, DC, Z
// - Destination bit: 0 accumulator, 1 file
// - Bit clear clears bit, flags untouched
// - Bit set sets bit, flags untouched
// - AND literal into accumulator, zero flag only
// - AND register routed by destination, zero only
// - Skip next when tested bit is zero
// - Skipped prefetch replaced by no-operation cycle
`timescale 1ns/100ps
`default_nettype none
module mce_exec
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// AXI4-Lite write
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Port pins
	input  wire logic [7:0]  portPinIn,
	output logic [7:0]       portPinOut,
	output logic [7:0]       portPinOe
);
	import mce_pkg::*;
	// ==========================================================
	// State
	logic [7:0]  acc_r, load_direction_instruction_r, timer_r, presc_r;
	logic        flagC_r, flagDc_r, flagZ_r, skipPend_r, assign_r;
	logic [8:0]  pc_r;
	logic [15:0] cycles_r;
	logic [11:0] lastInstr_r;
	logic [7:0]  fileMem_r [FILE_N];
	// ==========================================================
	// Bus decode
	logic        wrEn, rdEn, wrFile, wrKnown, rdKnown, exec;
	logic [31:0] rdNxt;
	assign wrEn   = awvalid & awready & wvalid & wready;
	assign rdEn   = arvalid & arready;
	assign wrFile = (awaddr[7] == OFF_FILE[7]) & (awaddr[1:0] == 2'h0);
	assign wrKnown = wrFile | (awaddr == OFF_INSTR) | (awaddr == OFF_ACC)
		| (awaddr == OFF_STATUS) | (awaddr == OFF_PC) | (awaddr == OFF_CTRL);
	// Instructions are 12 bits; a partial word is not executed
	assign exec = wrEn & (awaddr == OFF_INSTR) & (wstrb[1:0] == 2'h3);
	// ==========================================================
	// Decode
	mce_op_e     decOp, op;
	logic [11:0] instrIn;
	logic [4:0]  fAddr;
	logic [2:0]  bitSel;
	logic [7:0]  fileRd, statusVal, aluRes;
	logic        dBit, byteOp, bitOp, fileWr, accWr, aluC, aluDc, aluZ, presClr;
	assign instrIn = wdata[11:0];
	assign fAddr   = instrIn[4:0];
	assign dBit    = instrIn[5];
	assign bitSel  = instrIn[7:5];
	always_comb
	begin
		decOp = OP_NOP;
		unique casez (instrIn)
			PAT_TRIS6: decOp = OP_LOAD_DIRECTION_INSTRUCTION;
			PAT_MOVE_REGISTER_INSTR:  decOp = OP_MOVE_REGISTER_INSTR;
			PAT_ADD_REGISTER_INSTR: decOp = OP_ADD_REGISTER_INSTR;
			PAT_AND_REGISTER_INSTR: decOp = OP_AND_REGISTER_INSTR;
			PAT_BCF:   decOp = OP_BCF;
			PAT_BSF:   decOp = OP_BSF;
			PAT_SKIP_IF_BIT_ZERO_INSTR: decOp = OP_SKIP_IF_BIT_ZERO_INSTR;
			PAT_AND_LITERAL_INSTR: decOp = OP_AND_LITERAL_INSTR;
			PAT_UNCONDITIONAL_BRANCH:  decOp = OP_UNCONDITIONAL_BRANCH;
			default:   decOp = OP_NOP;
		endcase
	end
	// Prefetched word is dropped while a skip is pending
	assign op = skipPend_r ? OP_NOP : decOp;
	assign byteOp = (op == OP_MOVE_REGISTER_INSTR) | (op == OP_ADD_REGISTER_INSTR) | (op == OP_AND_REGISTER_INSTR);
	assign bitOp  = (op == OP_BCF) | (op == OP_BSF);
	assign fileWr = exec & ((byteOp & dBit) | bitOp);
	assign accWr  = exec & ((byteOp & ~dBit) | (op == OP_AND_LITERAL_INSTR));
	assign statusVal = {5'h00, flagZ_r, flagDc_r, flagC_r};

	// Port reads see the pins, not the output latch
	always_comb
	begin
		unique case (fAddr)
			F_PORT:   fileRd = portPinIn;
			F_TIMER:  fileRd = timer_r;
			F_PCL:    fileRd = pc_r[7:0];
			F_STATUS: fileRd = statusVal;
			default:  fileRd = fileMem_r[fAddr];
		endcase
	end
	mce_alu u_alu
	(
		.op        (op),
		.accIn     (acc_r),
		.fileIn    (fileRd),
		.lit       (instrIn[7:0]),
		.bitSel    (bitSel),
		.result    (aluRes),
		.carry     (aluC),
		.halfCarry (aluDc),
		.zero      (aluZ)
	);
	assign presClr = fileWr & (fAddr == F_TIMER) & assign_r;
	// ==========================================================
	// Bus write channel
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end
		else
		begin
			// Both channels taken together, one write in flight
			awready <= awvalid & wvalid & ~bvalid & ~awready;
			wready  <= awvalid & wvalid & ~bvalid & ~awready;
			if (wrEn)
			begin
				bvalid <= 1'b1;
				bresp  <= wrKnown ? RESP_OKAY : RESP_SLV;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end
	// ==========================================================
	// Bus read channel
	always_comb
	begin
		rdKnown = 1'b1;
		rdNxt   = 32'h0000_0000;
		if (araddr[7] == OFF_FILE[7])
			rdNxt[7:0] = fileMem_r[araddr[6:2]];
		else
			unique case (araddr)
				OFF_INSTR:  rdNxt[11:0] = lastInstr_r;
				OFF_ACC:    rdNxt[7:0]  = acc_r;
				OFF_STATUS: rdNxt[7:0]  = statusVal;
				OFF_PC:     rdNxt[8:0]  = pc_r;
				OFF_CTRL:   rdNxt[1:0]  = {skipPend_r, assign_r};
				OFF_LOAD_DIRECTION_INSTRUCTION:   rdNxt[7:0]  = load_direction_instruction_r;
				OFF_PRESC:  rdNxt[15:0] = {timer_r, presc_r};
				OFF_CYCLES: rdNxt[15:0] = cycles_r;
				default:    rdKnown = 1'b0;
			endcase
		if (araddr[1:0] != 2'h0)
			rdKnown = 1'b0;
	end
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
		end
		else
		begin
			arready <= arvalid & ~rvalid & ~arready;
			if (rdEn)
			begin
				rvalid <= 1'b1;
				rdata  <= rdKnown ? rdNxt : 32'h0000_0000;
				rresp  <= rdKnown ? RESP_OKAY : RESP_SLV;
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end
	// ==========================================================
	// Accumulator
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			acc_r <= ACC_RST;
		else if (accWr)
			acc_r <= aluRes;
		else if (wrEn & (awaddr == OFF_ACC) & wstrb[0])
			acc_r <= wdata[7:0];
	end
	// ==========================================================
	// Status flags; instruction flag updates beat a file write
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			flagC_r  <= 1'b0;
			flagDc_r <= 1'b0;
			flagZ_r  <= 1'b0;
		end
		else if (exec & (op == OP_ADD_REGISTER_INSTR))
		begin
			flagC_r  <= aluC;
			flagDc_r <= aluDc;
			flagZ_r  <= aluZ;
		end
		else if (exec & (byteOp | (op == OP_AND_LITERAL_INSTR)))
			flagZ_r <= aluZ;
		else if (fileWr & (fAddr == F_STATUS))
		begin
			// Bit ops reach flags only by addressing status itself
			flagC_r  <= aluRes[ST_C];
			flagDc_r <= aluRes[ST_DC];
			flagZ_r  <= aluRes[ST_Z];
		end
		else if (wrEn & (awaddr == OFF_STATUS) & wstrb[0])
		begin
			flagC_r  <= wdata[ST_C];
			flagDc_r <= wdata[ST_DC];
			flagZ_r  <= wdata[ST_Z];
		end
	end
	// ==========================================================
	// Program counter, skip and cycle count
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pc_r        <= PC_RST;
			skipPend_r  <= 1'b0;
			cycles_r    <= CYC_RST;
			lastInstr_r <= 12'h000;
		end
		else if (exec)
		begin
			cycles_r    <= cycles_r + 16'h0001;
			lastInstr_r <= instrIn;
			skipPend_r  <= (op == OP_SKIP_IF_BIT_ZERO_INSTR) & ~fileRd[bitSel];
			if (op == OP_UNCONDITIONAL_BRANCH)
				pc_r <= instrIn[8:0];
			else if (fileWr & (fAddr == F_PCL))
				pc_r <= {1'b0, aluRes};
			else
				pc_r <= pc_r + 9'h001;
		end
		else if (wrEn & (awaddr == OFF_PC) & (wstrb[1:0] == 2'h3))
			pc_r <= wdata[8:0];
	end
	// ==========================================================
	// General file registers
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < FILE_N; i++)
				fileMem_r[i] <= 8'h00;
		end
		else if (fileWr)
			fileMem_r[fAddr] <= aluRes;
		else if (wrEn & wrFile & wstrb[0])
			fileMem_r[awaddr[6:2]] <= wdata[7:0];
	end
	// ==========================================================
	// Port latch and direction
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			portPinOut <= PORT_RST;
			load_direction_instruction_r     <= LOAD_DIRECTION_INSTRUCTION_RST;
			portPinOe  <= ~LOAD_DIRECTION_INSTRUCTION_RST;
		end
		else
		begin
			if (fileWr & (fAddr == F_PORT))
				portPinOut <= aluRes;
			if (exec & (op == OP_LOAD_DIRECTION_INSTRUCTION))
			begin
				load_direction_instruction_r    <= acc_r;
				portPinOe <= ~acc_r;
			end
		end
	end
	// ==========================================================
	// Timer and prescaler; prescaler only runs when assigned
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			timer_r  <= 8'h00;
			presc_r  <= 8'h00;
			assign_r <= 1'b0;
		end
		else
		begin
			if (wrEn & (awaddr == OFF_CTRL) & wstrb[0])
				assign_r <= wdata[CTRL_ASSN];
			if (presClr)
				presc_r <= 8'h00;
			else if (assign_r)
				presc_r <= presc_r + 8'h01;
			if (fileWr & (fAddr == F_TIMER))
				timer_r <= aluRes;
			else if (~assign_r | (presc_r == 8'hFF))
				timer_r <= timer_r + 8'h01;
		end
	end
	// ==========================================================
	// Checks
	a_pc_bit_nine: assert property (@(posedge core_clk) disable iff (!arst_n)
		fileWr & (fAddr == F_PCL) |=> (pc_r[8] == 1'b0) && (pc_r[7:0] == $past(aluRes)))
		else $error("PC bit nine not cleared on file write");
	a_port_pins: assert property (@(posedge core_clk) disable iff (!arst_n)
		exec & (op == OP_MOVE_REGISTER_INSTR) & dBit & (fAddr == F_PORT) |=> portPinOut == $past(portPinIn))
		else $error("Port write-back did not use pin levels");
	a_load_direction_instruction_load: assert property (@(posedge core_clk) disable iff (!arst_n)
		exec & (op == OP_LOAD_DIRECTION_INSTRUCTION) |=> (portPinOe == ~$past(acc_r)) && (load_direction_instruction_r == $past(acc_r)))
		else $error("Direction latches not loaded from accumulator");
	a_presc_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
		exec & byteOp & dBit & (fAddr == F_TIMER) & assign_r |=> presc_r == 8'h00)
		else $error("Prescaler not cleared on timer write");
	a_add_sum: assert property (@(posedge core_clk) disable iff (!arst_n)
		exec & (op == OP_ADD_REGISTER_INSTR) & ~dBit |=> ({flagC_r, acc_r} == $past({1'b0, acc_r})
			+ $past({1'b0, fileRd})) && (flagZ_r == (acc_r == 8'h00)))
		else $error("Add result or flags wrong");
	a_dest_file: assert property (@(posedge core_clk) disable iff (!arst_n)
		exec & byteOp & dBit |=> $stable(acc_r))
		else $error("Accumulator changed with file destination");
	a_bit_flags: assert property (@(posedge core_clk) disable iff (!arst_n)
		exec & bitOp & (fAddr != F_STATUS) |=> $stable(statusVal))
		else $error("Bit op changed status flags");
	a_bit_set: assert property (@(posedge core_clk) disable iff (!arst_n)
		exec & (op == OP_BSF) & (fAddr[4:3] != 2'h0) |=> fileMem_r[$past(fAddr)] ==
			($past(fileRd) | (8'h01 << $past(bitSel))))
		else $error("Bit set result wrong");
	a_and_literal_instr_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
		exec & (op == OP_AND_LITERAL_INSTR) |=> (flagZ_r == (acc_r == 8'h00)) && $stable(flagC_r)
			&& $stable(flagDc_r))
		else $error("AND literal flags wrong");
	a_skip_taken: assert property (@(posedge core_clk) disable iff (!arst_n)
		exec & (op == OP_SKIP_IF_BIT_ZERO_INSTR) & ~fileRd[bitSel] |=> skipPend_r && $stable(statusVal))
		else $error("Skip not armed on clear bit");
	a_skip_nop: assert property (@(posedge core_clk) disable iff (!arst_n)
		exec & skipPend_r |=> !skipPend_r && $stable(acc_r) && (pc_r == $past(pc_r) + 9'h001))
		else $error("Skipped word was not a no-operation");
	c_skip_used: cover property (@(posedge core_clk) disable iff (!arst_n)
		exec & skipPend_r);
	c_load_direction_instruction_load: cover property (@(posedge core_clk) disable iff (!arst_n)
		exec & (op == OP_LOAD_DIRECTION_INSTRUCTION));
	c_add_carry: cover property (@(posedge core_clk) disable iff (!arst_n)
		exec & (op == OP_ADD_REGISTER_INSTR) & aluC & aluDc);
endmodule // mce_exec
`default_nettype wire

// ---- mce_exec_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module mce_exec_bench;
	import mce_pkg::*;
	// ==========================================================
	// Design ports
	logic        core_clk;
	logic        arst_n;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic [7:0]  portPinIn;
	logic [7:0]  portPinOut;
	logic [7:0]  portPinOe;
	int          badCount;
	int          nTests;
	int          cycles;
	logic [8:0]  epc;
	logic [15:0] ecnt;
	logic [7:0]  ex;
	logic [31:0] d;
	logic [1:0]  r;

	mce_exec DUT (.core_clk(core_clk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.portPinIn(portPinIn), .portPinOut(portPinOut), .portPinOe(portPinOe));

	// ==========================================================
	// Clock and hang guard
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Whole run is well under a thousand cycles; this ceiling only catches a stuck handshake
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			badCount++;
			closeOut();
		end
	end

	// ==========================================================
	// Checking and bus tasks
	task automatic closeOut();
		$display("checks %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp)
		begin
			badCount++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
		arvalid <= 1'b1;
		araddr  <= a;
		do @(posedge core_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready  <= 1'b1;
		do @(posedge core_clk); while (rvalid !== 1'b1);
		dv = rdata;
		rv = rresp;
		rready <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s,
		output logic [1:0] rv);
		logic aw;
		logic w;
		aw = 1'b0;
		w  = 1'b0;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		awaddr  <= a;
		wdata   <= dv;
		wstrb   <= s;
		while (!(aw && w))
		begin
			@(posedge core_clk);
			if (awready === 1'b1)
			begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1)
			begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge core_clk); while (bvalid !== 1'b1);
		rv = bresp;
		bready <= 1'b0;
	endtask

	task automatic chkRd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] dv;
		logic [1:0]  rv;
		rd(a, dv, rv);
		chk($sformatf("reg %h", a), dv, e);
	endtask

	task automatic setReg(input logic [7:0] a, input logic [7:0] v);
		logic [1:0] rv;
		wr(a, {24'h0, v}, 4'h1, rv);
	endtask

	// Every executed word, skipped ones too, advances the count by one, and PC by one unless the word loads PC
	task automatic exec(input logic [11:0] i);
		logic [1:0] rv;
		wr(OFF_INSTR, {20'h0, i}, 4'hF, rv);
		epc  = epc + 9'h001;
		ecnt = ecnt + 16'h0001;
	endtask

	function automatic logic [7:0] fa(input logic [4:0] f);
		return OFF_FILE + {1'b0, f, 2'b00};
	endfunction

	// ==========================================================
	// Main sequence
	initial
	begin
		arst_n = 1'b0;
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		portPinIn = 8'h00;
		badCount = 0;
		nTests = 0;
		cycles = 0;
		epc = 9'h000;
		ecnt = 16'h0000;
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		chkRd(OFF_ACC, 32'h0);
		chkRd(OFF_LOAD_DIRECTION_INSTRUCTION, 32'hFF);
		chk("oe", {24'h0, portPinOe}, 32'h0);
		// Unmapped place answers with an error
		wr(8'h40, 32'h1, 4'hF, r);
		chk("bresp", {30'h0, r}, {30'h0, RESP_SLV});
		rd(8'h40, d, r);
		chk("rresp", {30'h0, r}, {30'h0, RESP_SLV});
		// Add: nibble carry, then full carry with zero result back to file
		setReg(OFF_STATUS, 8'h00);
		setReg(fa(5'd8), 8'h0F);
		setReg(OFF_ACC, 8'h01);
		exec(12'h1C8);
		chkRd(OFF_ACC, 32'h10);
		chkRd(OFF_STATUS, 32'h02);
		chkRd(fa(5'd8), 32'h0F);
		setReg(fa(5'd9), 8'h10);
		setReg(OFF_ACC, 8'hF0);
		exec(12'h1E9);
		chkRd(fa(5'd9), 32'h00);
		chkRd(OFF_ACC, 32'hF0);
		chkRd(OFF_STATUS, 32'h05);
		// AND literal, carries left alone, literal 0x0F then the top of its range
		setReg(OFF_STATUS, 8'h03);
		exec(12'hE0F);
		chkRd(OFF_ACC, 32'h00);
		chkRd(OFF_STATUS, 32'h07);
		setReg(OFF_ACC, 8'h5A);
		exec(12'hEFF);
		chkRd(OFF_ACC, 32'h5A);
		chkRd(OFF_STATUS, 32'h03);
		// AND with file, both destinations
		setReg(OFF_ACC, 8'h3C);
		setReg(fa(5'd10), 8'hF0);
		exec(12'h16A);
		chkRd(fa(5'd10), 32'h30);
		chkRd(OFF_ACC, 32'h3C);
		setReg(fa(5'd11), 8'hC3);
		exec(12'h14B);
		chkRd(OFF_ACC, 32'h00);
		chkRd(OFF_STATUS, 32'h07);
		// Set then clear every bit position; flags must not move
		setReg(fa(5'd12), 8'h00);
		ex = 8'h00;
		for (int b = 0; b < 8; b++)
		begin
			exec({4'h5, 3'(b), 5'd12});
			ex[b] = 1'b1;
			chkRd(fa(5'd12), {24'h0, ex});
		end
		for (int b = 7; b >= 0; b--)
		begin
			exec({4'h4, 3'(b), 5'd12});
			ex[b] = 1'b0;
			chkRd(fa(5'd12), {24'h0, ex});
		end
		chkRd(OFF_STATUS, 32'h07);
		// Bit test: set bit runs the next word, clear bit turns it into a no-op
		setReg(fa(5'd13), 8'h04);
		setReg(OFF_ACC, 8'h5A);
		exec(12'h64D);
		exec(12'hEF0);
		chkRd(OFF_ACC, 32'h50);
		exec(12'h60D);
		chkRd(OFF_CTRL, 32'h2);
		exec(12'hE00);
		chkRd(OFF_ACC, 32'h50);
		chkRd(OFF_CTRL, 32'h0);
		chkRd(OFF_STATUS, 32'h03);
		chkRd(OFF_PC, {23'h0, epc});
		chkRd(OFF_CYCLES, {16'h0, ecnt});
		// Branch keeps bit nine, a file write to PC low drops it
		exec(12'hB80);
		epc = 9'h180;
		chkRd(OFF_PC, {23'h0, epc});
		setReg(OFF_ACC, 8'h00);
		exec(12'h162);
		epc = 9'h000;
		chkRd(OFF_PC, {23'h0, epc});
		// Port update reads the pins, not the latch
		portPinIn <= 8'hF0;
		repeat (4) @(posedge core_clk);
		exec(12'h506);
		chk("pins", {24'h0, portPinOut}, 32'hF1);
		portPinIn <= 8'h00;
		repeat (4) @(posedge core_clk);
		exec(12'h526);
		chk("pins", {24'h0, portPinOut}, 32'h02);
		// Move of the port onto itself copies the pins into the latch
		portPinIn <= 8'hA5;
		repeat (4) @(posedge core_clk);
		exec(12'h226);
		chk("pins", {24'h0, portPinOut}, 32'hA5);
		// Direction load only for file 6; one means released
		setReg(OFF_ACC, 8'h5A);
		exec(12'h006);
		chk("oe", {24'h0, portPinOe}, 32'hA5);
		chkRd(OFF_LOAD_DIRECTION_INSTRUCTION, 32'h5A);
		setReg(OFF_ACC, 8'hFF);
		exec(12'h007);
		chk("oe", {24'h0, portPinOe}, 32'hA5);
		// Prescaler: cleared by a timer write-back, kept when result goes to acc
		setReg(OFF_CTRL, 8'h01);
		repeat (150) @(posedge core_clk);
		rd(OFF_PRESC, d, r);
		chk("presc run", {31'h0, d[7:0] > 8'h40}, 32'h1);
		exec(12'h221);
		rd(OFF_PRESC, d, r);
		chk("presc clr", {31'h0, d[7:0] < 8'h10}, 32'h1);
		repeat (100) @(posedge core_clk);
		exec(12'h201);
		rd(OFF_PRESC, d, r);
		chk("presc kept", {31'h0, d[7:0] > 8'h40}, 32'h1);
		// Bit set on the timer clears the prescaler as well
		exec(12'h501);
		rd(OFF_PRESC, d, r);
		chk("presc bit", {31'h0, d[7:0] < 8'h10}, 32'h1);
		chkRd(OFF_CYCLES, {16'h0, ecnt});
		closeOut();
	end
endmodule // mce_exec_bench
`default_nettype wire

// ---- mce_pkg.sv ----
`default_nettype none
package mce_pkg;
	// ==========================================================
	// Widths
	localparam int DATA_W  = 8;
	localparam int PC_W    = 9;
	localparam int INSTR_W = 12;
	localparam int FILE_N  = 32;
	localparam int ADDR_W  = 8;

	// ==========================================================
	// Register offsets on the bus
	localparam logic [7:0] OFF_INSTR  = 8'h00;
	localparam logic [7:0] OFF_ACC    = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_PC     = 8'h0C;
	localparam logic [7:0] OFF_CTRL   = 8'h10;
	localparam logic [7:0] OFF_LOAD_DIRECTION_INSTRUCTION   = 8'h14;
	localparam logic [7:0] OFF_PRESC  = 8'h18;
	localparam logic [7:0] OFF_CYCLES = 8'h1C;
	localparam logic [7:0] OFF_FILE   = 8'h80;

	// ==========================================================
	// Special file addresses and field positions
	localparam logic [4:0] F_TIMER  = 5'h01;
	localparam logic [4:0] F_PCL    = 5'h02;
	localparam logic [4:0] F_STATUS = 5'h03;
	localparam logic [4:0] F_PORT   = 5'h06;
	localparam int ST_C      = 0;
	localparam int ST_DC     = 1;
	localparam int ST_Z      = 2;
	localparam int CTRL_ASSN = 0;
	localparam int CTRL_SKIP = 1;

	// ==========================================================
	// Reset values and bus answers
	localparam logic [7:0]  ACC_RST   = 8'h00;
	localparam logic [7:0]  LOAD_DIRECTION_INSTRUCTION_RST  = 8'hFF;
	localparam logic [7:0]  PORT_RST  = 8'h00;
	localparam logic [8:0]  PC_RST    = 9'h000;
	localparam logic [15:0] CYC_RST   = 16'h0000;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLV  = 2'h2;

	// ==========================================================
	// Instruction encodings
	localparam logic [11:0] PAT_TRIS6 = 12'b0000_0000_0110;
	localparam logic [11:0] PAT_MOVE_REGISTER_INSTR  = 12'b0010_00??_????;
	localparam logic [11:0] PAT_ADD_REGISTER_INSTR = 12'b0001_11??_????;
	localparam logic [11:0] PAT_AND_REGISTER_INSTR = 12'b0001_01??_????;
	localparam logic [11:0] PAT_BCF   = 12'b0100_????_????;
	localparam logic [11:0] PAT_BSF   = 12'b0101_????_????;
	localparam logic [11:0] PAT_SKIP_IF_BIT_ZERO_INSTR = 12'b0110_????_????;
	localparam logic [11:0] PAT_AND_LITERAL_INSTR = 12'b1110_????_????;
	localparam logic [11:0] PAT_UNCONDITIONAL_BRANCH  = 12'b101?_????_????;

	typedef enum logic [3:0] {
		OP_NOP, OP_LOAD_DIRECTION_INSTRUCTION, OP_MOVE_REGISTER_INSTR, OP_ADD_REGISTER_INSTR, OP_AND_REGISTER_INSTR,
		OP_BCF, OP_BSF, OP_SKIP_IF_BIT_ZERO_INSTR, OP_AND_LITERAL_INSTR, OP_UNCONDITIONAL_BRANCH
	} mce_op_e;
endpackage
`default_nettype wire
